//--- src/timer_pkg.sv
// Constants shared by the count-up timer and its prescaler.
// Assumes byte addresses on a classic Wishbone bus with 32-bit data.
package timer_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_PRELOAD = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_CLKCFG = 8'h14;

    // ----------------------------------------
    // Control field positions
    // ----------------------------------------
    localparam int MODE_HI_BIT = 7;
    localparam int MODE_LO_BIT = 6;
    localparam int RUN_BIT = 4;
    localparam int EDGE_BIT = 3;
    localparam int PSC_MSB = 2;
    localparam int PSC_LSB = 0;
    localparam logic [7:0] CONTROL_WMASK = 8'hdf;

    // ----------------------------------------
    // Status, mask and clock config fields
    // ----------------------------------------
    localparam int OVF_BIT = 0;
    localparam int PWDONE_BIT = 1;
    localparam int EVT_W = 2;
    localparam int DIV4_BIT = 0;

    // ----------------------------------------
    // Mode codes of the two-bit select field
    // ----------------------------------------
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TIMER = 2'h2;
    localparam logic [1:0] MODE_PULSE = 2'h3;

    // ----------------------------------------
    // Reset values and counts
    // ----------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PRELOAD_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_FULL = 8'hff;
    localparam logic [1:0] EVT_RESET = 2'h0;
    localparam logic [1:0] QUARTER_LAST = 2'h3;
    localparam int PRESCALE_W = 7;

endpackage

//--- src/prescale_if.sv
// Control and tick signals between the timer core and its prescaler.
// Assumes both ends run on the same clock.
interface prescale_if;
    logic run;
    logic div4;
    logic [2:0] ratio;
    logic tick;

    modport ctrl (output run, output div4, output ratio, input tick);
    modport presc (input run, input div4, input ratio, output tick);
endinterface

//--- src/prescaler.sv
// Count clock prescaler: system clock or a quarter of it, divided by 2^n.
// Assumes run, div4 and ratio come from logic on the same clock.
module prescaler (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    prescale_if.presc p
);

    logic [1:0] quarter;
    logic [timer_pkg::PRESCALE_W-1:0] pcount;
    wire base_tick;
    wire [timer_pkg::PRESCALE_W-1:0] ratio_mask;
    wire full;

    // ----------------------------------------
    // Base tick and ratio compare
    // ----------------------------------------
    assign base_tick = p.div4 ? (quarter == timer_pkg::QUARTER_LAST) : 1'b1;
    assign ratio_mask = timer_pkg::PRESCALE_W'((8'h01 << p.ratio) - 8'h01);
    assign full = (pcount & ratio_mask) == ratio_mask;

    // Dividers clear while stopped so each run starts a full period
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            quarter <= 2'h0;
            pcount <= '0;
            p.tick <= 1'b0;
        end else if (clk_en) begin
            if (!p.run) begin
                quarter <= 2'h0;
                pcount <= '0;
                p.tick <= 1'b0;
            end else begin
                quarter <= quarter + 2'h1;
                if (base_tick) begin
                    pcount <= full ? '0 : pcount + 7'h01;
                end
                p.tick <= base_tick & full;
            end
        end
    end

endmodule

//--- src/timer_block.sv
// 8-bit count-up timer/event counter with preload, prescaler and interrupt.
// Assumes a classic Wishbone master on clock and an asynchronous timer pin.
//
// How it works
// - Mode field 1,0 selects general timer mode
// - Timer counts system clock or its quarter
// - Run bit four lets the counter run
// - Counter adds one per count clock
// - Overflow raises interrupt, reloads preload, continues
// - Cleared interrupt enable suppresses overflow interrupt
// - Mode field 1,1 selects pulse width measurement
// - Bits two to zero pick prescale ratio
// - Preload loads counter when stopped, else overflow
//
// Design decisions made here: register access over Wishbone and the register addresses.
module timer_block (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timer_pin,
    output logic irq,
    output logic overflow_pulse
);

    // ----------------------------------------
    // Types and storage
    // ----------------------------------------
    typedef enum logic [0:0] {
        PW_WAIT,
        PW_MEASURE
    } pw_state_t;

    logic [7:0] control;
    logic [7:0] preload;
    logic [7:0] count;
    logic [timer_pkg::EVT_W-1:0] status;
    logic [timer_pkg::EVT_W-1:0] mask;
    logic div4;
    pw_state_t pw_state;
    pw_state_t next_pw_state;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;

    prescale_if psc ();

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    prescaler u_prescaler (
        .clock(clock),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .p(psc)
    );

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // Request, hits and strobes
    wire bus_req;
    wire bus_wr;
    wire hit_control;
    wire hit_preload;
    wire hit_count;
    wire hit_status;
    wire hit_mask;
    wire hit_clkcfg;
    wire wr_control;
    wire wr_preload;
    wire wr_status;
    wire wr_mask;
    wire wr_clkcfg;
    wire [7:0] wr_byte;
    wire [7:0] rd_byte;

    // New request only when no answer is pending
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    assign wr_byte = wb_dat_i[7:0];

    // Address compare per register
    assign hit_control = wb_adr_i == timer_pkg::OFF_CONTROL;
    assign hit_preload = wb_adr_i == timer_pkg::OFF_PRELOAD;
    assign hit_count = wb_adr_i == timer_pkg::OFF_COUNT;
    assign hit_status = wb_adr_i == timer_pkg::OFF_STATUS;
    assign hit_mask = wb_adr_i == timer_pkg::OFF_MASK;
    assign hit_clkcfg = wb_adr_i == timer_pkg::OFF_CLKCFG;

    // Write strobes
    assign wr_control = bus_wr & hit_control;
    assign wr_preload = bus_wr & hit_preload;
    assign wr_status = bus_wr & hit_status;
    assign wr_mask = bus_wr & hit_mask;
    assign wr_clkcfg = bus_wr & hit_clkcfg;

    // Read select; unmapped addresses read zero
    assign rd_byte = hit_control ? control :
                     hit_preload ? preload :
                     hit_count ? count :
                     hit_status ? {6'h00, status} :
                     hit_mask ? {6'h00, mask} :
                     hit_clkcfg ? {7'h00, div4} :
                     8'h00;

    // ----------------------------------------
    // Control field decode
    // ----------------------------------------
    wire [1:0] mode;
    wire running;
    wire edge_sel;
    wire mode_timer;
    wire mode_event;
    wire mode_pulse;

    // Mode, run and edge fields of the control byte
    assign mode = {control[timer_pkg::MODE_HI_BIT], control[timer_pkg::MODE_LO_BIT]};
    assign running = control[timer_pkg::RUN_BIT];
    assign edge_sel = control[timer_pkg::EDGE_BIT];
    assign mode_timer = mode == timer_pkg::MODE_TIMER;
    assign mode_event = mode == timer_pkg::MODE_EVENT;
    assign mode_pulse = mode == timer_pkg::MODE_PULSE;

    // Prescaler runs only for internal clock modes
    assign psc.run = running & (mode_timer | mode_pulse);
    assign psc.div4 = div4;
    assign psc.ratio = control[timer_pkg::PSC_MSB:timer_pkg::PSC_LSB];

    // ----------------------------------------
    // Timer pin synchroniser and edges
    // ----------------------------------------
    // Two flops tame the pin, a third keeps the last level
    // Reset to the pulled-up idle level so no false edge follows
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            pin_prev <= 1'b1;
        end else if (clk_en) begin
            pin_meta <= timer_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Edge strobes from the synchronised pin
    wire pin_rise;
    wire pin_fall;
    wire event_edge;
    wire start_edge;
    wire stop_edge;

    // Level change between the last two samples
    assign pin_rise = pin_sync & ~pin_prev;
    assign pin_fall = ~pin_sync & pin_prev;
    // Event mode: low selects rising, high selects falling
    assign event_edge = edge_sel ? pin_fall : pin_rise;
    // Pulse mode: low measures a low pulse, high a high pulse
    assign start_edge = edge_sel ? pin_rise : pin_fall;
    assign stop_edge = edge_sel ? pin_fall : pin_rise;

    // ----------------------------------------
    // Pulse width measurement sequence
    // ----------------------------------------
    wire pw_done;
    wire measuring;

    // Measuring between start and stop edge
    assign measuring = pw_state == PW_MEASURE;

    // Next measurement state; leaving pulse mode or stopping aborts
    always_comb begin
        next_pw_state = pw_state;
        if (!running || !mode_pulse) begin
            next_pw_state = PW_WAIT;
        end else begin
            case (pw_state)
                PW_WAIT: begin
                    if (start_edge) begin
                        next_pw_state = PW_MEASURE;
                    end
                end
                PW_MEASURE: begin
                    if (stop_edge) begin
                        next_pw_state = PW_WAIT;
                    end
                end
                default: begin
                    next_pw_state = PW_WAIT;
                end
            endcase
        end
    end

    // Stop edge (rise for a low pulse, fall for a high pulse) ends the measurement
    assign pw_done = running & mode_pulse & measuring & stop_edge;

    // Measurement state register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pw_state <= PW_WAIT;
        end else if (clk_en) begin
            pw_state <= next_pw_state;
        end
    end

    // ----------------------------------------
    // Count clock and overflow
    // ----------------------------------------
    wire count_tick;
    wire at_full;
    wire overflow;

    // One count per internal tick or active pin edge
    assign count_tick = running & ((mode_timer & psc.tick) |
                                   (mode_event & event_edge) |
                                   (mode_pulse & psc.tick & measuring));
    // Overflow is a count clock arriving at full count
    assign at_full = count == timer_pkg::COUNT_FULL;
    assign overflow = count_tick & at_full;

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    wire [7:0] control_wdata;

    // Unimplemented bit dropped on the way in
    assign control_wdata = wr_byte & timer_pkg::CONTROL_WMASK;

    // Software write wins over the hardware stop
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            control <= timer_pkg::CONTROL_RESET;
        end else if (clk_en) begin
            if (wr_control) begin
                control <= control_wdata;
            end else if (pw_done) begin
                control[timer_pkg::RUN_BIT] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Clock config and mask registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            div4 <= 1'b0;
            mask <= timer_pkg::EVT_RESET;
        end else if (clk_en) begin
            if (wr_clkcfg) begin
                div4 <= wr_byte[timer_pkg::DIV4_BIT];
            end
            if (wr_mask) begin
                mask <= wr_byte[timer_pkg::EVT_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // Preload and counter
    // ----------------------------------------
    // A new preload only reaches a running counter at overflow
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            preload <= timer_pkg::PRELOAD_RESET;
        end else if (clk_en) begin
            if (wr_preload) begin
                preload <= wr_byte;
            end
        end
    end

    logic [7:0] next_count;

    // Stopped preload write, then reload, then increment
    always_comb begin
        next_count = count;
        if (wr_preload && !running) begin
            next_count = wr_byte;
        end else if (overflow) begin
            next_count = preload;
        end else if (count_tick) begin
            next_count = count + 8'h01;
        end
    end

    // Counter register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            count <= timer_pkg::COUNT_RESET;
        end else if (clk_en) begin
            count <= next_count;
        end
    end

    // ----------------------------------------
    // Interrupt status and output
    // ----------------------------------------
    wire [timer_pkg::EVT_W-1:0] evt_set;
    wire [timer_pkg::EVT_W-1:0] evt_clr;
    wire [timer_pkg::EVT_W-1:0] next_status;
    wire next_irq;

    // Hardware events and write-one clears
    assign evt_set = {pw_done, overflow};
    assign evt_clr = wr_status ? wr_byte[timer_pkg::EVT_W-1:0] : timer_pkg::EVT_RESET;
    // Set beats a clear in the same cycle
    assign next_status = (status & ~evt_clr) | evt_set;
    // Level request from any unmasked pending event
    assign next_irq = |(next_status & mask);

    // Status, request and overflow strobe registers
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            status <= timer_pkg::EVT_RESET;
            irq <= 1'b0;
            overflow_pulse <= 1'b0;
        end else if (clk_en) begin
            status <= next_status;
            irq <= next_irq;
            overflow_pulse <= overflow;
        end
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    // One-cycle acknowledge, read data latched with it
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (clk_en) begin
            wb_ack_o <= bus_req;
            if (bus_req) begin
                wb_dat_o <= {24'h00_0000, rd_byte};
            end
        end
    end

endmodule

//--- bench/timer_block_props.sv
// Concurrent checks on the timer block's bus, interrupt and overflow ports.
// Assumes a classic Wishbone master and the package offsets and fields.
module timer_block_props (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic timer_pin,
    input wire logic irq,
    input wire logic overflow_pulse
);
    // ----------------------------------------
    // Shadow of control and mask writes
    // ----------------------------------------
    logic [7:0] sh_ctrl;
    logic [1:0] sh_mask;

    // Write taken at this edge, per register
    wire take_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en && wb_we_i && wb_sel_i[0];
    wire wr_ctrl = take_wr && wb_adr_i == timer_pkg::OFF_CONTROL;
    wire wr_mask = take_wr && wb_adr_i == timer_pkg::OFF_MASK;
    wire rd_ack = wb_ack_o && !wb_we_i;

    // Shadow registers follow bus writes
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sh_ctrl <= 8'h00;
            sh_mask <= 2'h0;
        end else begin
            sh_ctrl <= wr_ctrl ? wb_dat_i[7:0] : sh_ctrl;
            sh_mask <= wr_mask ? wb_dat_i[1:0] : sh_mask;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_CTRL_READ: assert property (rd_ack && wb_adr_i == timer_pkg::OFF_CONTROL
        && sh_ctrl[7:6] != timer_pkg::MODE_PULSE |-> wb_dat_o[7:0] == (sh_ctrl & timer_pkg::CONTROL_WMASK))
        else $error("control read differs from written value");
    AST_UNMAPPED: assert property (rd_ack && wb_adr_i > timer_pkg::OFF_CLKCFG |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_IRQ_MASK: assert property (irq |-> sh_mask != 2'h0 || $past(sh_mask) != 2'h0
        || $past(sh_mask, 2) != 2'h0) else $error("irq high with all sources masked");
    AST_IRQ_FALL: assert property ($fell(irq) |-> !$past(rst_b) || $past(take_wr)
        || $past(take_wr, 2)) else $error("irq fell without a register write");
    AST_OVF_RUN: assert property (overflow_pulse |-> $past(sh_ctrl[4]) || $past(sh_ctrl[4], 2))
        else $error("overflow while stopped");
    AST_OVF_MODE: assert property (overflow_pulse |-> $past(sh_ctrl[7:6]) != 2'h0
        || $past(sh_ctrl[7:6], 2) != 2'h0) else $error("overflow with no mode selected");
endmodule

bind timer_block timer_block_props u_props (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_pin(timer_pin), .irq(irq), .overflow_pulse(overflow_pulse));

//--- bench/tb_top.sv
// Self-checking bench for the timer block over its Wishbone port.
// Assumes the package offsets and a 200 MHz single clock.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, rst_b, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, timer_pin;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, d, g;
    logic wb_ack_o, irq, overflow_pulse;
    int fails = 0;
    int total_checks = 0;

    timer_block u_dut (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_pin(timer_pin),
        .irq(irq), .overflow_pulse(overflow_pulse));

    // ----------------------------------------
    // Compare and closing report
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Bus and overflow helpers
    // ----------------------------------------
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        input logic [3:0] sel, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, sel, dat};
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            fails++;
            close_out();
        end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] v);
        logic [31:0] x;
        xfer(1'b1, adr, {24'h0, v}, 4'h1, x);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] x;
        xfer(1'b0, adr, 32'h0, 4'h1, x);
        check(x, exp);
    endtask

    task automatic wait_ovf(output logic [31:0] n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (overflow_pulse !== 1'b1 && n < 32'd9000);
        if (overflow_pulse !== 1'b1) begin
            fails++;
            close_out();
        end
    endtask

    // Cycles between two consecutive overflows
    task automatic ovf_gap(output logic [31:0] n);
        wait_ovf(n);
        wait_ovf(n);
    endtask

    // Clock at 200 MHz
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        rst_b = 1'b0;
        clk_en = 1'b1;
        timer_pin = 1'b1;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        for (int a = 0; a < 6; a++) rd_chk(8'(a * 4), 32'h0);
        wr(8'h20, 8'hff);
        rd_chk(8'h20, 32'h0);
        wr(timer_pkg::OFF_CONTROL, 8'h2f);
        rd_chk(timer_pkg::OFF_CONTROL, 32'h0f);
        xfer(1'b1, timer_pkg::OFF_CONTROL, 32'h0, 4'h0, d);
        rd_chk(timer_pkg::OFF_CONTROL, 32'h0f);
        wr(timer_pkg::OFF_PRELOAD, 8'hf0);
        rd_chk(timer_pkg::OFF_COUNT, 32'hf0);
        // Running with no mode, then pulse mode with a steady pin
        wr(timer_pkg::OFF_CONTROL, 8'h10);
        repeat (40) @(posedge clock);
        rd_chk(timer_pkg::OFF_COUNT, 32'hf0);
        wr(timer_pkg::OFF_CONTROL, 8'hd0);
        repeat (40) @(posedge clock);
        rd_chk(timer_pkg::OFF_COUNT, 32'hf0);
        timer_pin <= 1'b0;
        repeat (8) @(posedge clock);
        timer_pin <= 1'b1;
        repeat (10) @(posedge clock);
        rd_chk(timer_pkg::OFF_CONTROL, 32'hc0);
        rd_chk(timer_pkg::OFF_STATUS, 32'h2);
        rd_chk(timer_pkg::OFF_COUNT, 32'hf8);
        wr(timer_pkg::OFF_CONTROL, 8'h00);
        wr(timer_pkg::OFF_STATUS, 8'h03);
        wr(timer_pkg::OFF_PRELOAD, 8'hf0);
        // Timer mode at every prescale ratio, then the quarter clock
        for (int n = 0; n < 8; n++) begin
            wr(timer_pkg::OFF_CONTROL, 8'h90 | 8'(n));
            ovf_gap(g);
            check(g, 32'd16 << n);
        end
        wr(timer_pkg::OFF_CLKCFG, 8'h01);
        wr(timer_pkg::OFF_CONTROL, 8'h91);
        ovf_gap(g);
        check(g, 32'd128);
        wr(timer_pkg::OFF_CLKCFG, 8'h00);
        // Interrupt: masked, enabled, masked again, cleared
        check({31'h0, irq}, 32'h0);
        rd_chk(timer_pkg::OFF_STATUS, 32'h1);
        wr(timer_pkg::OFF_MASK, 8'h01);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h1);
        wr(timer_pkg::OFF_MASK, 8'h00);
        @(posedge clock);
        check({31'h0, irq}, 32'h0);
        wr(timer_pkg::OFF_MASK, 8'h01);
        wr(timer_pkg::OFF_CONTROL, 8'h00);
        wr(timer_pkg::OFF_STATUS, 8'h01);
        @(posedge clock);
        check({31'h0, irq}, 32'h0);
        // Event mode counts pin edges, prescale ignored
        for (int e = 0; e < 2; e++) begin
            wr(timer_pkg::OFF_CONTROL, 8'h00);
            wr(timer_pkg::OFF_PRELOAD, 8'h00);
            wr(timer_pkg::OFF_CONTROL, 8'h57 | 8'(e << 3));
            repeat (3) begin
                timer_pin <= 1'b0;
                repeat (4) @(posedge clock);
                timer_pin <= 1'b1;
                repeat (4) @(posedge clock);
            end
            repeat (4) @(posedge clock);
            rd_chk(timer_pkg::OFF_COUNT, 32'h3);
        end
        wr(timer_pkg::OFF_CONTROL, 8'h00);
        wr(timer_pkg::OFF_PRELOAD, 8'hf0);
        // Preload written while running waits for the next overflow
        wr(timer_pkg::OFF_CONTROL, 8'h94);
        wait_ovf(g);
        wr(timer_pkg::OFF_PRELOAD, 8'h10);
        xfer(1'b0, timer_pkg::OFF_COUNT, 32'h0, 4'h1, d);
        check({28'h0, d[7:4]}, 32'hf);
        ovf_gap(g);
        check(g, 32'd3840);
        // Clock enable low freezes the count between overflows
        clk_en <= 1'b0;
        repeat (100) @(posedge clock);
        clk_en <= 1'b1;
        wait_ovf(g);
        check(g, 32'd3840);
        close_out();
    end
endmodule
